// ### common/sdsl_pkg.sv
// Shared constants and types for the switcher drive and safety logic.
package sdsl_pkg;
  // Clock rate and the timing figures derived from it.
  localparam int CLK_MHZ = 20;
  localparam int ONESHOT_NS = 500;
  localparam int FLY_DELAY_NS = 1000;
  localparam int SOFT_STEP_NS = 100;
  // Least times round up to whole cycles and never fall below one.
  localparam int ONESHOT_CYC = (ONESHOT_NS * CLK_MHZ + 999) / 1000 < 1 ? 1
                               : (ONESHOT_NS * CLK_MHZ + 999) / 1000;
  localparam int FLY_DELAY_CYC = (FLY_DELAY_NS * CLK_MHZ + 999) / 1000 < 1
                                 ? 1 : (FLY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int SOFT_STEP_CYC = (SOFT_STEP_NS * CLK_MHZ + 999) / 1000 < 1
                                 ? 1 : (SOFT_STEP_NS * CLK_MHZ + 999) / 1000;
  // Over-voltage confirmation delay in horizontal lines.
  localparam int OVP_LINES = 2;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  // Control register fields and reset value.
  localparam int CTRL_W = 9;
  localparam int CB_ENABLE = 0;
  localparam int CB_POLARITY = 1;
  localparam int CB_MUTE = 2;
  localparam int CB_EDGE = 3;
  localparam int CB_CUTOFF = 4;
  localparam int CB_BLANK = 5;
  localparam int CB_VERT = 6;
  localparam int CB_PHASE = 7;
  localparam int CB_LINE = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h020;
  // Command register field.
  localparam int CMD_PROT_RESET = 0;
  // Synchroniser bit positions.
  localparam int SY_W = 14;
  localparam int SY_HDRIVE = 0;
  localparam int SY_FLYMID = 1;
  localparam int SY_RAMPTOP = 2;
  localparam int SY_LOCK = 3;
  localparam int SY_VSYNC = 4;
  localparam int SY_VDIS = 5;
  localparam int SY_CUR = 6;
  localparam int SY_REG = 7;
  localparam int SY_SOFT = 8;
  localparam int SY_STOP_TOP = 9;
  localparam int SY_STOP_ZERO = 10;
  localparam int SY_OVP = 11;
  localparam int SY_PROT_SUP = 12;
  localparam int SY_SUPPLY = 13;
  // Converter drive sequencing states.
  typedef enum logic [1:0] {
    CV_OFF, CV_START, CV_RUN, CV_STOP
  } sdsl_cv_state_t;
endpackage

// ### common/sdsl_sync_if.sv
// Interface carrying raw pins into the synchroniser and clean bits back.
`timescale 1ns/1ps
interface sdsl_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport src (output raw, input clean);
  modport syn (input raw, output clean);
endinterface

// ### logic/sdsl_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs.
`timescale 1ns/1ps
module sdsl_sync #(
  parameter int W = 1
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  sdsl_sync_if.syn sif
);
  // One pair of flops per bit; only the second flop is ever read.
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_ff;
      logic hold_ff;
      always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          meta_ff <= 1'b0;
          hold_ff <= 1'b0;
        end else begin
          meta_ff <= sif.raw[gi];
          hold_ff <= meta_ff;
        end
      end
      assign sif.clean[gi] = hold_ff;
    end
  endgenerate
endmodule

// ### logic/sdsl_top.sv
// Converter drive latch, soft sequencing, protection and composite output.
// Function
// - Drive output level follows polarity bit; pulses run at line rate, or half of it in half-line mode.
// - Phase and edge bits choose the latch set event among four.
// - Set event fires a one-shot; drive turns on when it ends.
// - Current-limit comparator resets the drive latch.
// - Regulation comparator also resets the latch, ORed with current limit.
// - Half-line mode sets only on every second oscillator ramp top.
// - Soft start on switch-on, soft stop on switch-off, incl. alarm clear.
// - Mute cuts only the converter drive at once, no soft stop.
// - Unmuting restarts the converter through internally timed soft start.
// - With cut-off enabled, unlock cuts converter drive immediately.
// - With cut-off enabled, relock starts internally timed soft start.
// - Line drive comes on first and goes off last.
// - Over-voltage arms only above threshold with protection supply present.
// - After two lines of detection, both drives are inhibited.
// - Trip sets the readable over-voltage alarm flag to one.
// - Trip stays latched until supply drop or host reset bit.
// - Lock and blanking combine onto one four-level composite output.
// - Blanking starts at first leading edge of vsync or discharge.
// - Blanking ends at trailing edge of discharge pulse.
// - Permanent blank select holds composite at lock-matched blank level.
// - Low supply, trip or vertical disable force permanent blanking.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module sdsl_top #(
  parameter int INT_RAMP_W = 6
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  output logic wb_ack_out,
  input wire logic line_timing_in,
  input wire logic flyback_mid_in,
  input wire logic oscillator_ramp_top_in,
  input wire logic line_phase_loop_lock_in,
  input wire logic vsync_in,
  input wire logic vdischarge_in,
  input wire logic current_limit_cmp_in,
  input wire logic regulation_cmp_in,
  input wire logic soft_limit_cmp_in,
  input wire logic soft_ramp_top_in,
  input wire logic soft_ramp_zero_in,
  input wire logic overvoltage_detect_in,
  input wire logic protection_supply_level_in,
  input wire logic supply_enable_level_in,
  output logic soft_ramp_charge_out,
  output logic line_drive_out,
  output logic converter_drive_out,
  output logic [1:0] lock_blank_composite_out
);
  localparam logic [7:0] ONESHOT_LD = 8'(sdsl_pkg::ONESHOT_CYC);
  localparam logic [7:0] FLY_LD = 8'(sdsl_pkg::FLY_DELAY_CYC);
  localparam logic [1:0] OVP_LAST = 2'(sdsl_pkg::OVP_LINES - 1);

  // Pin inputs pass the synchroniser bank before any logic reads them.
  sdsl_sync_if #(.W(sdsl_pkg::SY_W)) sync_if ();
  assign sync_if.raw = {supply_enable_level_in, protection_supply_level_in,
                        overvoltage_detect_in, soft_ramp_zero_in,
                        soft_ramp_top_in, soft_limit_cmp_in,
                        regulation_cmp_in, current_limit_cmp_in,
                        vdischarge_in, vsync_in, line_phase_loop_lock_in,
                        oscillator_ramp_top_in, flyback_mid_in,
                        line_timing_in};

  sdsl_sync #(.W(sdsl_pkg::SY_W)) u_sync (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .sif(sync_if.syn)
  );

  logic [sdsl_pkg::SY_W-1:0] s;
  logic [sdsl_pkg::SY_W-1:0] s_d_ff;
  assign s = sync_if.clean;

  // Delayed copies for edge detection of the clean bits.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_d_ff <= '0;
    end else begin
      s_d_ff <= s;
    end
  end

  logic hd_rise;
  logic hd_fall;
  logic fly_rise;
  logic top_rise;
  logic vs_rise;
  logic vd_rise;
  logic vd_fall;
  logic lock;
  logic supply_ok;
  assign hd_rise = s[sdsl_pkg::SY_HDRIVE] & ~s_d_ff[sdsl_pkg::SY_HDRIVE];
  assign hd_fall = ~s[sdsl_pkg::SY_HDRIVE] & s_d_ff[sdsl_pkg::SY_HDRIVE];
  assign fly_rise = s[sdsl_pkg::SY_FLYMID] & ~s_d_ff[sdsl_pkg::SY_FLYMID];
  assign top_rise = s[sdsl_pkg::SY_RAMPTOP] & ~s_d_ff[sdsl_pkg::SY_RAMPTOP];
  assign vs_rise = s[sdsl_pkg::SY_VSYNC] & ~s_d_ff[sdsl_pkg::SY_VSYNC];
  assign vd_rise = s[sdsl_pkg::SY_VDIS] & ~s_d_ff[sdsl_pkg::SY_VDIS];
  assign vd_fall = ~s[sdsl_pkg::SY_VDIS] & s_d_ff[sdsl_pkg::SY_VDIS];
  assign lock = s[sdsl_pkg::SY_LOCK];
  assign supply_ok = s[sdsl_pkg::SY_SUPPLY];

  // Wishbone slave: one wait state, ack for exactly one cycle.
  logic [sdsl_pkg::CTRL_W-1:0] ctrl_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic wr_take;
  logic prot_reset;
  logic trip_ff;
  logic line_on_ff;
  sdsl_pkg::sdsl_cv_state_t cv_ff;
  logic [31:0] nxt_rdat;

  assign wr_take = wb_cyc_in & wb_stb_in & wb_we_in & ack_ff;
  assign prot_reset = wr_take & (wb_adr_in == sdsl_pkg::REG_CMD) &
                      wb_sel_in[0] & wb_dat_in[sdsl_pkg::CMD_PROT_RESET];
  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdat_ff;

  // Read mux; unmapped addresses answer with zero.
  always_comb begin
    nxt_rdat = 32'h0000_0000;
    case (wb_adr_in)
      sdsl_pkg::REG_CTRL: begin
        nxt_rdat[sdsl_pkg::CTRL_W-1:0] = ctrl_ff;
      end
      sdsl_pkg::REG_STAT: begin
        nxt_rdat[0] = trip_ff;
        nxt_rdat[1] = lock;
        nxt_rdat[2] = line_on_ff;
        nxt_rdat[4:3] = cv_ff;
      end
      default: begin
        nxt_rdat = 32'h0000_0000;
      end
    endcase
  end

  // Acknowledge the cycle after the request appears, then drop it.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_cyc_in & wb_stb_in & ~ack_ff;
      rdat_ff <= nxt_rdat;
    end
  end

  // Control register, written byte lane by byte lane at the ack edge.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_ff <= sdsl_pkg::CTRL_RESET;
    end else if (wr_take && wb_adr_in == sdsl_pkg::REG_CTRL) begin
      if (wb_sel_in[0]) begin
        ctrl_ff[7:0] <= wb_dat_in[7:0];
      end
      if (wb_sel_in[1]) begin
        ctrl_ff[8] <= wb_dat_in[8];
      end
    end
  end

  logic en_bit;
  logic mute_bit;
  logic cutoff_bit;
  logic quick_off;
  assign en_bit = ctrl_ff[sdsl_pkg::CB_ENABLE];
  assign mute_bit = ctrl_ff[sdsl_pkg::CB_MUTE];
  assign cutoff_bit = ctrl_ff[sdsl_pkg::CB_CUTOFF];
  // Mute and unlock cut-off skip the soft stop entirely.
  assign quick_off = mute_bit | (cutoff_bit & ~lock);

  // Over-voltage: count whole lines while armed; a drop of the arm resets the count.
  logic ovp_arm;
  logic [1:0] ovp_cnt_ff;
  logic trip_set;
  assign ovp_arm = s[sdsl_pkg::SY_OVP] & s[sdsl_pkg::SY_PROT_SUP];
  assign trip_set = ovp_arm & hd_rise & (ovp_cnt_ff == OVP_LAST);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovp_cnt_ff <= 2'h0;
    end else if (!ovp_arm || trip_ff) begin
      ovp_cnt_ff <= 2'h0;
    end else if (hd_rise) begin
      ovp_cnt_ff <= ovp_cnt_ff + 2'h1;
    end
  end

  // The trip latches; a new trip in the clearing cycle still wins.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trip_ff <= 1'b0;
    end else if (trip_set) begin
      trip_ff <= 1'b1;
    end else if (prot_reset || !supply_ok) begin
      trip_ff <= 1'b0;
    end
  end

  // Line drive gate: on at once, off only once the converter is idle.
  logic line_want;
  assign line_want = ctrl_ff[sdsl_pkg::CB_LINE] & supply_ok & ~trip_ff;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_on_ff <= 1'b0;
    end else if (line_want) begin
      line_on_ff <= 1'b1;
    end else if (cv_ff == sdsl_pkg::CV_OFF) begin
      line_on_ff <= 1'b0;
    end
  end

  // Converter sequencing; clearing the alarm restores cv_want and so
  // passes through soft start like an enable does.
  logic cv_want;
  logic int_soft_ff;
  logic [INT_RAMP_W-1:0] int_ramp_ff;
  logic ramp_done;
  sdsl_pkg::sdsl_cv_state_t nxt_cv;
  assign cv_want = en_bit & line_want & line_on_ff;
  assign ramp_done = int_soft_ff ? (&int_ramp_ff)
                     : s[sdsl_pkg::SY_STOP_TOP];

  always_comb begin
    nxt_cv = cv_ff;
    case (cv_ff)
      sdsl_pkg::CV_OFF: begin
        if (cv_want && !quick_off) begin
          nxt_cv = sdsl_pkg::CV_START;
        end
      end
      sdsl_pkg::CV_START: begin
        if (!cv_want) begin
          nxt_cv = sdsl_pkg::CV_STOP;
        end else if (ramp_done) begin
          nxt_cv = sdsl_pkg::CV_RUN;
        end
      end
      sdsl_pkg::CV_RUN: begin
        if (!cv_want) begin
          nxt_cv = sdsl_pkg::CV_STOP;
        end
      end
      sdsl_pkg::CV_STOP: begin
        if (cv_want) begin
          nxt_cv = sdsl_pkg::CV_START;
        end else if (s[sdsl_pkg::SY_STOP_ZERO]) begin
          nxt_cv = sdsl_pkg::CV_OFF;
        end
      end
      default: begin
        nxt_cv = sdsl_pkg::CV_OFF;
      end
    endcase
    if (quick_off) begin
      nxt_cv = sdsl_pkg::CV_OFF;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cv_ff <= sdsl_pkg::CV_OFF;
    end else begin
      cv_ff <= nxt_cv;
    end
  end

  // A quick cut-off leaves no external ramp to follow, so the next
  // start is paced by the internal line-counted ramp instead.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_soft_ff <= 1'b0;
    end else if (quick_off && cv_ff != sdsl_pkg::CV_OFF) begin
      int_soft_ff <= 1'b1;
    end else if (cv_ff == sdsl_pkg::CV_RUN) begin
      int_soft_ff <= 1'b0;
    end
  end

  // Internal ramp climbs one step per line during an internal start.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_ramp_ff <= '0;
    end else if (cv_ff != sdsl_pkg::CV_START || !int_soft_ff) begin
      int_ramp_ff <= '0;
    end else if (hd_rise && !(&int_ramp_ff)) begin
      int_ramp_ff <= int_ramp_ff + INT_RAMP_W'(1);
    end
  end

  // The ramp pin charges while starting or running, discharges otherwise.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_ramp_charge_out <= 1'b0;
    end else begin
      soft_ramp_charge_out <= (nxt_cv == sdsl_pkg::CV_START) |
                              (nxt_cv == sdsl_pkg::CV_RUN);
    end
  end

  // Set event selection: half-line ramp top, delayed flyback, or edges.
  logic half_ff;
  logic [7:0] fly_cnt_ff;
  logic set_ev;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      half_ff <= 1'b0;
    end else if (top_rise) begin
      half_ff <= ~half_ff;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fly_cnt_ff <= 8'h00;
    end else if (fly_rise) begin
      fly_cnt_ff <= FLY_LD;
    end else if (fly_cnt_ff != 8'h00) begin
      fly_cnt_ff <= fly_cnt_ff - 8'h01;
    end
  end

  always_comb begin
    case ({ctrl_ff[sdsl_pkg::CB_PHASE], ctrl_ff[sdsl_pkg::CB_EDGE]})
      2'b01: set_ev = top_rise & half_ff;
      2'b00: set_ev = (fly_cnt_ff == 8'h01);
      2'b10: set_ev = hd_fall;
      default: set_ev = hd_rise;
    endcase
  end

  // One-shot after the set event; the latch sets as it expires.
  logic [7:0] os_cnt_ff;
  logic os_end;
  assign os_end = (os_cnt_ff == 8'h01);
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      os_cnt_ff <= 8'h00;
    end else if (set_ev) begin
      os_cnt_ff <= ONESHOT_LD;
    end else if (os_cnt_ff != 8'h00) begin
      os_cnt_ff <= os_cnt_ff - 8'h01;
    end
  end

  // Drive latch, reset dominant so a comparator always ends the pulse.
  logic latch_ff;
  logic [15:0] on_cnt_ff;
  logic active;
  logic soft_ext;
  logic int_limit;
  logic latch_rst;
  assign active = (cv_ff != sdsl_pkg::CV_OFF);
  assign soft_ext = ~int_soft_ff & ((cv_ff == sdsl_pkg::CV_START) |
                    (cv_ff == sdsl_pkg::CV_STOP)) & s[sdsl_pkg::SY_SOFT];
  assign int_limit = int_soft_ff & (cv_ff == sdsl_pkg::CV_START) &
                     (on_cnt_ff >= 16'(int_ramp_ff) *
                      16'(sdsl_pkg::SOFT_STEP_CYC));
  assign latch_rst = s[sdsl_pkg::SY_CUR] | s[sdsl_pkg::SY_REG] |
                     soft_ext | int_limit | ~active;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      latch_ff <= 1'b0;
    end else if (latch_rst) begin
      latch_ff <= 1'b0;
    end else if (os_end) begin
      latch_ff <= 1'b1;
    end
  end

  // On-time counter used only by the internal soft start limit.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      on_cnt_ff <= 16'h0000;
    end else if (!latch_ff) begin
      on_cnt_ff <= 16'h0000;
    end else if (on_cnt_ff != 16'hFFFF) begin
      on_cnt_ff <= on_cnt_ff + 16'h0001;
    end
  end

  // Registered drive outputs; polarity applies to the converter pin.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      converter_drive_out <= 1'b0;
      line_drive_out <= 1'b0;
    end else begin
      converter_drive_out <= latch_ff ^
                             ctrl_ff[sdsl_pkg::CB_POLARITY];
      line_drive_out <= s[sdsl_pkg::SY_HDRIVE] & line_on_ff;
    end
  end

  // Early blanking: either leading edge starts it, discharge end stops.
  logic blank_ff;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      blank_ff <= 1'b0;
    end else if (vs_rise || vd_rise) begin
      blank_ff <= 1'b1;
    end else if (vd_fall) begin
      blank_ff <= 1'b0;
    end
  end

  // Composite: bit1 is lock, bit0 is blanking, four distinct codes.
  logic blank_any;
  assign blank_any = blank_ff | ctrl_ff[sdsl_pkg::CB_BLANK] |
                     ~supply_ok | trip_ff |
                     ~ctrl_ff[sdsl_pkg::CB_VERT];
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lock_blank_composite_out <= 2'h1;
    end else begin
      lock_blank_composite_out <= {lock, blank_any};
    end
  end
endmodule

// ### dv/sdsl_props.sv
// Port-level checker for the switcher drive and safety block.
`timescale 1ns/1ps
module sdsl_props (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic line_phase_loop_lock_in,
  input wire logic vdischarge_in,
  input wire logic supply_enable_level_in,
  input wire logic [1:0] lock_blank_composite_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // Bus answers are single pulses, one cycle after a fresh request.
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property
    ($rose(wb_cyc_in && wb_stb_in) |=> wb_ack_out)
    else $error("request not answered in one cycle");
  a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without a request");
  // Reads outside the control and status words return zero.
  a_unmapped_zero: assert property (wb_ack_out && !wb_we_in &&
    wb_adr_in != sdsl_pkg::REG_CTRL && wb_adr_in != sdsl_pkg::REG_STAT
    |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  // Synchronisers add latency, so each level must hold a few cycles.
  a_supply_blank: assert property
    (!supply_enable_level_in [*4] |-> lock_blank_composite_out[0])
    else $error("low supply without blanking");
  a_lock_high: assert property
    (line_phase_loop_lock_in [*5] |-> lock_blank_composite_out[1])
    else $error("lock not shown on composite");
  a_lock_low: assert property
    (!line_phase_loop_lock_in [*5] |-> !lock_blank_composite_out[1])
    else $error("unlock not shown on composite");
  a_discharge_blank: assert property
    (vdischarge_in [*6] |-> lock_blank_composite_out[0])
    else $error("discharge pulse without blanking");
endmodule
bind sdsl_top sdsl_props u_props (.mclk_in, .rstn_in, .wb_adr_in,
  .wb_we_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out,
  .line_phase_loop_lock_in, .vdischarge_in, .supply_enable_level_in,
  .lock_blank_composite_out);

// ### dv/sdsl_far_side.sv
// Power switch, current sense ramp and soft ramp capacitor model.
`timescale 1ns/1ps
module sdsl_far_side #(
  parameter int LIM = 20,
  parameter int TOP = 16
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic drive_in,
  input wire logic pol_in,
  input wire logic charge_in,
  output logic cur_out,
  output logic soft_out,
  output logic top_out,
  output logic zero_out
);
  int cur_ff;
  int lvl_ff;
  // Sense ramp climbs while the switch conducts and drops when it opens.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) cur_ff <= 0;
    else cur_ff <= (drive_in ^ pol_in) ? cur_ff + 1 : 0;
  end
  // Capacitor charges one unit a cycle; real ramps are slower.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) lvl_ff <= 0;
    else if (charge_in && lvl_ff < TOP) lvl_ff <= lvl_ff + 1;
    else if (!charge_in && lvl_ff > 0) lvl_ff <= lvl_ff - 1;
  end
  // Comparators seen by the drive latch (current, soft) and the sequencer (top, zero).
  assign cur_out = cur_ff >= LIM;
  assign soft_out = cur_ff >= lvl_ff;
  assign top_out = lvl_ff == TOP;
  assign zero_out = lvl_ff == 0;
endmodule

// ### dv/test_switcher_drive_and_safety_logic.sv
// Self-checking bench for the switcher drive and safety block.
`timescale 1ns/1ps
module test_switcher_drive_and_safety_logic;
  logic mclk_in = 0, rstn_in = 0, we = 0, cyc = 0, stb = 0;
  logic [7:0] adr = 8'h0;
  logic [31:0] dat = 32'h0, rd, ctrl_m;
  logic lt = 0, fm = 0, rt = 0, lock = 1, vs = 0, vd = 0, rg = 0;
  logic ovd = 0, psup = 1, sup = 1, pol;
  wire logic cur, sl, st, sz, chg, ld, cd, ack;
  wire logic [1:0] comp;
  wire logic [31:0] dout;
  int failures = 0, n_tests = 0, lc = 0, seed = 79254;
  int ev[4] = '{75, 85, 45, 15};
  assign pol = ctrl_m[1];
  initial forever #25 mclk_in = ~mclk_in;
  // Line timebase: drive edge, mid flyback and ramp top each line.
  always @(posedge mclk_in) begin
    lc <= (lc + 1) % 100;
    lt <= lc < 30;
    fm <= lc >= 40 && lc < 43;
    rt <= lc >= 70 && lc < 73;
  end
  sdsl_top #(.INT_RAMP_W(2)) dut_u (.mclk_in, .rstn_in, .wb_adr_in(adr),
    .wb_dat_in(dat), .wb_dat_out(dout), .wb_we_in(we), .wb_sel_in(4'hF),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_ack_out(ack),
    .line_timing_in(lt), .flyback_mid_in(fm), .oscillator_ramp_top_in(rt),
    .line_phase_loop_lock_in(lock), .vsync_in(vs), .vdischarge_in(vd),
    .current_limit_cmp_in(cur), .regulation_cmp_in(rg),
    .soft_limit_cmp_in(sl), .soft_ramp_top_in(st), .soft_ramp_zero_in(sz),
    .overvoltage_detect_in(ovd), .protection_supply_level_in(psup),
    .supply_enable_level_in(sup), .soft_ramp_charge_out(chg),
    .line_drive_out(ld), .converter_drive_out(cd),
    .lock_blank_composite_out(comp));
  sdsl_far_side far_u (.mclk_in, .rstn_in, .drive_in(cd), .pol_in(pol),
    .charge_in(chg), .cur_out(cur), .soft_out(sl), .top_out(st),
    .zero_out(sz));
  task automatic close_out;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Classic cycle; read data is taken at the edge that samples ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_in);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    for (k = 0; k < 50 && ack !== 1'b1; k++) @(posedge mclk_in);
    if (ack !== 1'b1) begin
      failures++;
      close_out();
    end else begin
      // Ack and read data are taken at the edge that sampled ack high.
      rd = dout;
      {cyc, stb} <= 2'b00;
      // Return after the next edge so registered effects have settled.
      @(posedge mclk_in);
      @(negedge mclk_in);
    end
  endtask
  task automatic wr(input logic [31:0] v);
    ctrl_m = v;
    wb(1, sdsl_pkg::REG_CTRL, v);
  endtask
  // Counts switch turn-ons and line drive pulses over whole lines.
  task automatic cnt(input int lines, output int n, output int nl);
    logic p, q;
    n = 0;
    nl = 0;
    p = cd ^ pol;
    q = ld;
    repeat (lines * 100) begin
      @(negedge mclk_in);
      if ((cd ^ pol) === 1'b1 && p === 1'b0) n++;
      if (ld === 1'b1 && q === 1'b0) nl++;
      p = cd ^ pol;
      q = ld;
    end
  endtask
  // Line position of the next turn-on, and the line drive level then.
  task automatic dly(output int d, output logic l);
    logic p;
    d = -1;
    p = cd ^ pol;
    for (int i = 0; i < 300 && d < 0; i++) begin
      @(negedge mclk_in);
      if ((cd ^ pol) === 1'b1 && p === 1'b0) d = lc;
      l = ld;
      p = cd ^ pol;
    end
    if (d < 0) begin
      failures++;
      close_out();
    end
  endtask
  task automatic stat(input int b, input logic [31:0] e, input string nm);
    wb(0, sdsl_pkg::REG_STAT, 32'h0);
    chk(nm, (rd >> b) & 32'h1, e);
  endtask
  // Waits for a line position; a line is 100 cycles, so it must come.
  task automatic at_lc(input int v);
    for (int j = 0; j < 100 && lc != v; j++) @(negedge mclk_in);
    if (lc != v) begin
      failures++;
      close_out();
    end
  endtask
  initial begin
    int n, nl, d;
    logic l;
    ctrl_m = 32'h020;
    repeat (12) @(posedge mclk_in);
    rstn_in <= 1;
    wb(0, sdsl_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", rd, ctrl_m);
    wb(1, 8'h10, 32'h1FF);
    wb(1, sdsl_pkg::REG_STAT, 32'h1F);
    wb(0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    wr($random(seed) & 32'h0FE);
    wb(0, sdsl_pkg::REG_CTRL, 32'h0);
    chk("ctrl rw", rd, ctrl_m);
    stat(0, 0, "alarm idle");
    $display("registers done");
    // Every set event, its line position and its pulse rate.
    for (int i = 0; i < 4; i++) begin
      wr(32'h161 | (i[1] << 7) | (i[0] << 3));
      cnt(3, n, nl);
      dly(d, l);
      chk("set delay", d >= ev[i] - 3 && d <= ev[i] + 3, 1);
      if (i == 3) chk("line first", l, 1);
      cnt(4, n, nl);
      chk("pulses", n, i == 1 ? 2 : 4);
    end
    wr(ctrl_m | 32'h2);
    cnt(2, n, nl);
    chk("inverted pulses", n, 2);
    at_lc(60);
    chk("idle high", cd, 1'b1);
    wr(ctrl_m & ~32'h2);
    @(posedge mclk_in) rg <= 1;
    cnt(2, n, nl);
    chk("regulation cut", n, 0);
    @(posedge mclk_in) rg <= 0;
    $display("drive done");
    wr(ctrl_m | 32'h4);
    cnt(2, n, nl);
    chk("muted", n, 0);
    chk("line runs", nl, 2);
    wr(ctrl_m & ~32'h4);
    cnt(10, n, nl);
    cnt(2, n, nl);
    chk("unmuted", n, 2);
    wr(ctrl_m | 32'h10);
    @(posedge mclk_in) lock <= 0;
    cnt(2, n, nl);
    chk("unlock cut", n, 0);
    chk("unlock code", comp[1], 0);
    @(posedge mclk_in) lock <= 1;
    cnt(10, n, nl);
    cnt(2, n, nl);
    chk("relocked", n, 2);
    wr(ctrl_m & ~32'h1);
    chk("soft stop", chg, 0);
    cnt(2, n, nl);
    stat(3, 0, "state off");
    stat(4, 0, "state off high");
    wr(ctrl_m | 32'h1);
    cnt(2, n, nl);
    chk("soft start", chg, 1);
    $display("sequencing done");
    @(posedge mclk_in) {psup, ovd} <= 2'b01;
    cnt(4, n, nl);
    stat(0, 0, "no supply no trip");
    at_lc(50);
    @(posedge mclk_in) psup <= 1;
    cnt(1, n, nl);
    stat(0, 0, "one line");
    cnt(1, n, nl);
    stat(0, 1, "tripped");
    @(posedge mclk_in) ovd <= 0;
    cnt(2, n, nl);
    chk("line inhibited", nl, 0);
    chk("drive inhibited", n, 0);
    chk("trip blank", comp[0], 1);
    stat(0, 1, "latched");
    wb(1, sdsl_pkg::REG_CMD, 32'h1);
    cnt(10, n, nl);
    stat(0, 0, "cleared");
    cnt(2, n, nl);
    chk("restart", n, 2);
    @(posedge mclk_in) sup <= 0;
    repeat (10) @(posedge mclk_in);
    sup <= 1;
    $display("protection done");
    wr(ctrl_m & ~32'h20);
    repeat (6) @(negedge mclk_in);
    chk("video", comp[0], 0);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_in) {vs, vd} <= i ? 2'b01 : 2'b10;
      repeat (6) @(negedge mclk_in);
      chk("blank start", comp[0], 1);
      @(posedge mclk_in) vs <= 0;
      repeat (6) @(negedge mclk_in);
      chk("blank held", comp[0], i ? 1'b1 : 1'b1);
      @(posedge mclk_in) vd <= 1;
      repeat (6) @(posedge mclk_in);
      vd <= 0;
      repeat (6) @(negedge mclk_in);
      chk("blank end", comp[0], 0);
    end
    wr(ctrl_m | 32'h20);
    chk("permanent", comp[0], 1);
    wr(ctrl_m & ~32'h60);
    chk("vertical off", comp[0], 1);
    $display("composite done");
    close_out();
  end
endmodule
